// ---- design/thermal_measure_unit.sv ----
// Thermal measure unit: oscillator counting, scaling, window monitor, flags, APB slave.
// Assumes one clock pclk; oscillator and start event arrive asynchronously.
`timescale 1ns/1ps
module thermal_measure_unit (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         clk_en,
  input  wire thermal_measure_pkg::apb_req_s apb_req,
  output      thermal_measure_pkg::apb_rsp_s apb_rsp,
  input  wire logic                         temp_dependent_oscillator,
  input  wire logic                         start_event_in,
  input  wire logic                         standby_sleep,
  input  wire logic                         debug_halt,
  output      logic                         osc_config_max,
  output      logic                         irq,
  output      logic                         dma_req,
  output      logic                         window_event
);
  import thermal_measure_pkg::*;

  apb_rsp_s                   rsp_r;
  logic                       access;
  logic                       done;
  logic                       wr;
  logic                       rd;
  logic [IDX_W-1:0]           idx;
  logic                       mapped;
  logic                       err_nxt;
  logic [DATA_W-1:0]          rdata_nxt;
  logic [DATA_W-1:0]          wd;
  logic                       wr_ok;

  logic                       enable_wr_r;
  logic                       enable_r;
  logic                       sb_enable_r;
  logic                       sb_soft_reset_r;
  logic [SYNC_CNT_W-1:0]      sync_cnt_r;
  logic                       sync_fire;
  logic                       soft_rst;
  logic                       prot_ok;

  logic                       standby_run_r;
  logic                       continuous_mode_r;
  logic [WIN_W-1:0]           window_select_r;
  logic                       start_event_in_en_r;
  logic                       start_event_invert_r;
  logic                       window_event_out_en_r;
  logic [FLAG_W-1:0]          irq_enable_r;
  logic [FLAG_W-1:0]          irq_flags_r;
  logic [VALUE_W-1:0]         lower_threshold_r;
  logic [VALUE_W-1:0]         upper_threshold_r;
  logic [VALUE_W-1:0]         gain_r;
  logic [VALUE_W-1:0]         offset_r;
  logic [CAL_W-1:0]           fcal_r;
  logic [CAL_W-1:0]           tcal_r;
  logic                       debug_run_r;
  logic [VALUE_W-1:0]         value_r;
  logic                       status_ovf_r;
  logic                       unread_r;
  logic                       hyst_r;

  logic                       osc_s1_r;
  logic                       osc_s2_r;
  logic                       osc_s3_r;
  logic                       osc_edge;
  logic                       ev_s1_r;
  logic                       ev_s2_r;
  logic                       ev_s3_r;
  logic                       ev_edge;

  meas_state_e                state_r;
  logic [VALUE_W-1:0]         phase_cnt_r;
  logic signed [VALUE_W-1:0]  diff_r;
  logic                       phase_end;
  logic                       run_ok;
  logic                       start_req;
  logic signed [VALUE_W:0]    sum_w;
  logic signed [VALUE_W-1:0]  res;
  logic                       too_wide;
  logic signed [VALUE_W-1:0]  lo_s;
  logic signed [VALUE_W-1:0]  up_s;
  logic                       win_match;
  logic                       store;

  // APB decode
  assign access = apb_req.psel & apb_req.penable;
  assign done   = access & rsp_r.pready;
  assign wd     = apb_req.pwdata;
  assign idx    = apb_req.paddr[ADDR_IDX_HI:ADDR_IDX_LO];
  assign wr     = done & apb_req.pwrite;
  assign wr_ok  = wr & ~rsp_r.pslverr;
  assign rd     = done & ~apb_req.pwrite & ~rsp_r.pslverr;
  assign prot_ok = ~enable_r & ~enable_wr_r;

  always_comb begin
    mapped = (apb_req.paddr[ADDR_W-1:ADDR_IDX_HI+1] == '0);
    case (idx)
      IDX_CTRL_A, IDX_CTRL_B, IDX_CTRL_C, IDX_EVENT, IDX_IRQ_CLR, IDX_IRQ_SET,
      IDX_IRQ_FLAG, IDX_STATUS, IDX_SYNC, IDX_VALUE, IDX_LOWER, IDX_UPPER,
      IDX_GAIN, IDX_OFFSET, IDX_CAL, IDX_DEBUG: mapped = mapped;
      default: mapped = 1'b0;
    endcase
  end

  // Busy control write is refused
  assign err_nxt = ~mapped | (apb_req.pwrite & idx == IDX_CTRL_A & (sb_enable_r | sb_soft_reset_r));

  always_comb begin
    rdata_nxt = DATA_ZERO;
    case (idx)
      IDX_CTRL_A: begin
        rdata_nxt[CA_SOFT_RESET]    = sb_soft_reset_r;
        rdata_nxt[CA_ENABLE]   = enable_wr_r;
        rdata_nxt[CA_STBY_RUN] = standby_run_r;
      end
      IDX_CTRL_C: begin
        rdata_nxt[CC_WIN_LO +: WIN_W] = window_select_r;
        rdata_nxt[CC_CONTINUOUS_MODE]         = continuous_mode_r;
      end
      IDX_EVENT: begin
        rdata_nxt[EV_START_EN] = start_event_in_en_r;
        rdata_nxt[EV_INVERT]   = start_event_invert_r;
        rdata_nxt[EV_WIN_OUT]  = window_event_out_en_r;
      end
      IDX_IRQ_CLR, IDX_IRQ_SET: rdata_nxt[FLAG_W-1:0] = irq_enable_r;
      IDX_IRQ_FLAG: rdata_nxt[FLAG_W-1:0] = irq_flags_r;
      IDX_STATUS: rdata_nxt[0] = status_ovf_r;
      IDX_SYNC: begin
        rdata_nxt[SB_SOFT_RESET]  = sb_soft_reset_r;
        rdata_nxt[SB_ENABLE] = sb_enable_r;
      end
      IDX_VALUE:  rdata_nxt[VALUE_W-1:0] = value_r;
      IDX_LOWER:  rdata_nxt[VALUE_W-1:0] = lower_threshold_r;
      IDX_UPPER:  rdata_nxt[VALUE_W-1:0] = upper_threshold_r;
      IDX_GAIN:   rdata_nxt[VALUE_W-1:0] = gain_r;
      IDX_OFFSET: rdata_nxt[VALUE_W-1:0] = offset_r;
      IDX_CAL: begin
        rdata_nxt[CAL_FCAL_LO +: CAL_W] = fcal_r;
        rdata_nxt[CAL_TCAL_LO +: CAL_W] = tcal_r;
      end
      IDX_DEBUG: rdata_nxt[DBG_RUN] = debug_run_r;
      default: rdata_nxt = DATA_ZERO;
    endcase
  end

  // One wait state; response held in flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_r <= '0;
    end else if (clk_en) begin
      rsp_r.pready <= access & ~rsp_r.pready;
      if (access & ~rsp_r.pready) begin
        rsp_r.prdata  <= mapped ? rdata_nxt : DATA_ZERO;
        rsp_r.pslverr <= err_nxt;
      end else begin
        rsp_r.prdata  <= DATA_ZERO;
        rsp_r.pslverr <= 1'b0;
      end
    end
  end
  assign apb_rsp = rsp_r;

  // Synchronisation of enable and soft reset
  assign sync_fire = (sb_enable_r | sb_soft_reset_r) & (sync_cnt_r == SYNC_CNT_W'(1));
  assign soft_rst  = sync_fire & sb_soft_reset_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_wr_r <= 1'b0;
      enable_r    <= 1'b0;
      sb_enable_r <= 1'b0;
      sb_soft_reset_r  <= 1'b0;
      sync_cnt_r  <= '0;
    end else if (clk_en) begin
      if (wr_ok && idx == IDX_CTRL_A) begin
        sync_cnt_r <= SYNC_CNT_W'(SYNC_CYCLES);
        if (wd[CA_SOFT_RESET]) begin
          sb_soft_reset_r <= 1'b1;
        end else begin
          sb_enable_r <= 1'b1;
          enable_wr_r <= wd[CA_ENABLE];
        end
      end else if (sync_cnt_r != '0) begin
        sync_cnt_r <= sync_cnt_r - SYNC_CNT_W'(1);
      end
      if (sync_fire) begin
        sb_enable_r <= 1'b0;
        sb_soft_reset_r  <= 1'b0;
        if (sb_soft_reset_r) begin
          enable_r    <= 1'b0;
          enable_wr_r <= 1'b0;
        end else begin
          enable_r <= enable_wr_r;
        end
      end
    end
  end

  // Enable-protected configuration; soft reset clears these
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_run_r         <= 1'b0;
      continuous_mode_r     <= 1'b0;
      window_select_r       <= WM_OFF;
      start_event_in_en_r   <= 1'b0;
      start_event_invert_r  <= 1'b0;
      window_event_out_en_r <= 1'b0;
      lower_threshold_r     <= VALUE_RST;
      upper_threshold_r     <= VALUE_RST;
    end else if (clk_en) begin
      if (soft_rst) begin
        standby_run_r         <= 1'b0;
        continuous_mode_r     <= 1'b0;
        window_select_r       <= WM_OFF;
        start_event_in_en_r   <= 1'b0;
        start_event_invert_r  <= 1'b0;
        window_event_out_en_r <= 1'b0;
        lower_threshold_r     <= VALUE_RST;
        upper_threshold_r     <= VALUE_RST;
      end else if (wr_ok && prot_ok) begin
        case (idx)
          IDX_CTRL_A: if (!wd[CA_SOFT_RESET]) standby_run_r <= wd[CA_STBY_RUN];
          IDX_CTRL_C: begin
            continuous_mode_r <= wd[CC_CONTINUOUS_MODE];
            window_select_r   <= wd[CC_WIN_LO +: WIN_W];
          end
          IDX_EVENT: begin
            start_event_in_en_r   <= wd[EV_START_EN];
            start_event_invert_r  <= wd[EV_INVERT];
            window_event_out_en_r <= wd[EV_WIN_OUT];
          end
          IDX_LOWER: lower_threshold_r <= wd[VALUE_W-1:0];
          IDX_UPPER: upper_threshold_r <= wd[VALUE_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // Calibration and debug registers survive soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_r      <= VALUE_RST;
      offset_r    <= VALUE_RST;
      fcal_r      <= '0;
      tcal_r      <= '0;
      debug_run_r <= 1'b0;
    end else if (clk_en && wr_ok) begin
      if (prot_ok) begin
        case (idx)
          IDX_GAIN:   gain_r <= wd[VALUE_W-1:0];
          IDX_OFFSET: offset_r <= wd[VALUE_W-1:0];
          IDX_CAL: begin
            fcal_r <= wd[CAL_FCAL_LO +: CAL_W];
            tcal_r <= wd[CAL_TCAL_LO +: CAL_W];
          end
          default: ;
        endcase
      end
      if (idx == IDX_DEBUG) debug_run_r <= wd[DBG_RUN];
    end
  end

  // Input synchronisers and edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      ev_s1_r  <= 1'b0;
      ev_s2_r  <= 1'b0;
      ev_s3_r  <= 1'b0;
    end else if (clk_en) begin
      osc_s1_r <= temp_dependent_oscillator;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      ev_s1_r  <= start_event_in;
      ev_s2_r  <= ev_s1_r;
      ev_s3_r  <= ev_s2_r;
    end
  end
  assign osc_edge = osc_s2_r & ~osc_s3_r;
  assign ev_edge  = start_event_invert_r ? (~ev_s2_r & ev_s3_r) : (ev_s2_r & ~ev_s3_r);

  // Measurement sequencing
  assign run_ok = enable_r & ~(standby_sleep & ~standby_run_r)
                & ~(debug_halt & ~debug_run_r);
  assign start_req = (wr_ok & idx == IDX_CTRL_B & wd[CB_START])
                   | (ev_edge & start_event_in_en_r)
                   | continuous_mode_r;
  assign phase_end = (phase_cnt_r + VALUE_W'(1)) >= gain_r;
  assign store     = (state_r == ST_STORE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= ST_IDLE;
      phase_cnt_r <= '0;
      diff_r      <= '0;
      osc_config_max <= 1'b0;
    end else if (clk_en) begin
      if (!enable_r || soft_rst) begin
        state_r        <= ST_IDLE;
        osc_config_max <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: if (start_req && run_ok) begin
            state_r        <= ST_MIN;
            phase_cnt_r    <= '0;
            diff_r         <= '0;
            osc_config_max <= 1'b0;
          end
          ST_MIN: begin
            if (osc_edge) diff_r <= diff_r + VALUE_W'(1);
            phase_cnt_r <= phase_cnt_r + VALUE_W'(1);
            if (phase_end) begin
              state_r        <= ST_MAX;
              phase_cnt_r    <= '0;
              osc_config_max <= 1'b1;
            end
          end
          ST_MAX: begin
            if (osc_edge) diff_r <= diff_r - VALUE_W'(1);
            phase_cnt_r <= phase_cnt_r + VALUE_W'(1);
            if (phase_end) begin
              state_r        <= ST_STORE;
              osc_config_max <= 1'b0;
            end
          end
          ST_STORE: begin
            if (continuous_mode_r && run_ok) begin
              state_r     <= ST_MIN;
              phase_cnt_r <= '0;
              diff_r      <= '0;
            end else begin
              state_r <= ST_IDLE;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Scaling, range check and window comparison
  assign sum_w    = {offset_r[VALUE_W-1], offset_r} + {diff_r[VALUE_W-1], diff_r};
  assign res      = sum_w[VALUE_W-1:0];
  assign too_wide = (sum_w[VALUE_W:RESULT_W-1] != '0)
                  && (sum_w[VALUE_W:RESULT_W-1] != '1);
  assign lo_s     = lower_threshold_r;
  assign up_s     = upper_threshold_r;

  always_comb begin
    case (window_select_r)
      WM_ABOVE:      win_match = res > lo_s;
      WM_BELOW:      win_match = res < up_s;
      WM_INSIDE:     win_match = (res > lo_s) && (res < up_s);
      WM_OUTSIDE:    win_match = (res < lo_s) || (res > up_s);
      WM_HYST_ABOVE: win_match = hyst_r ? (res > lo_s) : (res > up_s);
      WM_HYST_BELOW: win_match = hyst_r ? (res < up_s) : (res < lo_s);
      default:       win_match = 1'b0;
    endcase
  end

  // Result, flags, interrupt enables and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_r      <= VALUE_RST;
      status_ovf_r <= 1'b0;
      unread_r     <= 1'b0;
      hyst_r       <= 1'b0;
      irq_flags_r  <= FLAG_RST;
      irq_enable_r <= FLAG_RST;
      irq          <= 1'b0;
      dma_req      <= 1'b0;
      window_event <= 1'b0;
    end else if (clk_en) begin
      if (soft_rst) begin
        value_r      <= VALUE_RST;
        status_ovf_r <= 1'b0;
        unread_r     <= 1'b0;
        hyst_r       <= 1'b0;
        irq_flags_r  <= FLAG_RST;
        irq_enable_r <= FLAG_RST;
        irq          <= 1'b0;
        dma_req      <= 1'b0;
        window_event <= 1'b0;
      end else begin
        if (wr_ok && idx == IDX_IRQ_SET) irq_enable_r <= irq_enable_r | wd[FLAG_W-1:0];
        if (wr_ok && idx == IDX_IRQ_CLR) irq_enable_r <= irq_enable_r & ~wd[FLAG_W-1:0];
        irq_flags_r <= (irq_flags_r & ~((wr_ok && idx == IDX_IRQ_FLAG) ? wd[FLAG_W-1:0] : FLAG_RST))
                     | ({FLAG_W{store}} & {too_wide, win_match, unread_r, 1'b1});
        if (store) begin
          value_r      <= res;
          status_ovf_r <= too_wide;
          hyst_r       <= win_match;
        end
        unread_r     <= store | (unread_r & ~(rd && idx == IDX_VALUE));
        dma_req      <= store | (dma_req & ~(rd && idx == IDX_VALUE));
        irq          <= |(irq_flags_r & irq_enable_r);
        window_event <= store & win_match & window_event_out_en_r;
      end
    end
  end

endmodule

// ---- design/thermal_measure_pkg.sv ----
// Constants, register map and carrier types for the thermal measure unit.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
package thermal_measure_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_TIME_NS  = 30;
  localparam int SYNC_CYCLES   = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CNT_W    = 4;

  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 32;
  localparam int ADDR_IDX_HI = 9;
  localparam int ADDR_IDX_LO = 2;
  localparam int IDX_W       = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL_A   = 8'h00;
  localparam logic [IDX_W-1:0] IDX_CTRL_B   = 8'h01;
  localparam logic [IDX_W-1:0] IDX_CTRL_C   = 8'h02;
  localparam logic [IDX_W-1:0] IDX_EVENT    = 8'h03;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR  = 8'h04;
  localparam logic [IDX_W-1:0] IDX_IRQ_SET  = 8'h05;
  localparam logic [IDX_W-1:0] IDX_IRQ_FLAG = 8'h06;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 8'h07;
  localparam logic [IDX_W-1:0] IDX_SYNC     = 8'h08;
  localparam logic [IDX_W-1:0] IDX_VALUE    = 8'h0C;
  localparam logic [IDX_W-1:0] IDX_LOWER    = 8'h10;
  localparam logic [IDX_W-1:0] IDX_UPPER    = 8'h14;
  localparam logic [IDX_W-1:0] IDX_GAIN     = 8'h18;
  localparam logic [IDX_W-1:0] IDX_OFFSET   = 8'h1C;
  localparam logic [IDX_W-1:0] IDX_CAL      = 8'h20;
  localparam logic [IDX_W-1:0] IDX_DEBUG    = 8'h24;

  // Field positions
  localparam int CA_SOFT_RESET    = 0;
  localparam int CA_ENABLE   = 1;
  localparam int CA_STBY_RUN = 6;
  localparam int CB_START    = 0;
  localparam int CC_WIN_LO   = 0;
  localparam int CC_CONTINUOUS_MODE  = 4;
  localparam int EV_START_EN = 0;
  localparam int EV_INVERT   = 1;
  localparam int EV_WIN_OUT  = 2;
  localparam int FL_RDY      = 0;
  localparam int FL_OVERRUN  = 1;
  localparam int FL_WIN      = 2;
  localparam int FL_OVF      = 3;
  localparam int FLAG_W      = 4;
  localparam int SB_SOFT_RESET    = 0;
  localparam int SB_ENABLE   = 1;
  localparam int CAL_FCAL_LO = 0;
  localparam int CAL_TCAL_LO = 8;
  localparam int CAL_W       = 6;
  localparam int DBG_RUN     = 0;

  localparam int VALUE_W  = 24;
  localparam int RESULT_W = 16;
  localparam int WIN_W    = 3;

  localparam logic [VALUE_W-1:0] VALUE_RST = 24'h00_0000;
  localparam logic [FLAG_W-1:0]  FLAG_RST  = 4'h0;
  localparam logic [DATA_W-1:0]  DATA_ZERO = 32'h0000_0000;

  localparam logic [WIN_W-1:0] WM_OFF        = 3'h0;
  localparam logic [WIN_W-1:0] WM_ABOVE      = 3'h1;
  localparam logic [WIN_W-1:0] WM_BELOW      = 3'h2;
  localparam logic [WIN_W-1:0] WM_INSIDE     = 3'h3;
  localparam logic [WIN_W-1:0] WM_OUTSIDE    = 3'h4;
  localparam logic [WIN_W-1:0] WM_HYST_ABOVE = 3'h5;
  localparam logic [WIN_W-1:0] WM_HYST_BELOW = 3'h6;

  typedef enum logic [1:0] {ST_IDLE, ST_MIN, ST_MAX, ST_STORE} meas_state_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_s;

endpackage

// ---- verification/thermal_measure_monitor.sv ----
// Port checker for the thermal measure unit.
// Assumes every port is sampled on pclk; bound in from the testbench top.
`timescale 1ns/1ps
module thermal_measure_monitor (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire thermal_measure_pkg::apb_req_s apb_req,
  input wire thermal_measure_pkg::apb_rsp_s apb_rsp,
  input wire logic                          osc_config_max,
  input wire logic                          irq,
  input wire logic                          dma_req,
  input wire logic                          window_event
);
  import thermal_measure_pkg::*;
  logic       done;
  logic       wr;
  logic       rdv;
  logic [2:0] age_r;
  assign done = apb_req.psel & apb_req.penable & apb_rsp.pready;
  assign wr   = done & apb_req.pwrite;
  assign rdv  = done & !apb_req.pwrite & (apb_req.paddr[ADDR_IDX_HI:ADDR_IDX_LO] == IDX_VALUE);
  // Cycles since the last completed write, refused ones included, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) age_r <= 3'h7;
    else if (wr) age_r <= 3'h0;
    else if (age_r != 3'h7) age_r <= age_r + 3'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait: assert property ($rose(apb_req.penable) && apb_req.psel |=> apb_rsp.pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held");
  a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  a_unmapped_zero: assert property (done && apb_req.paddr[11:10] != 2'h0
    |-> apb_rsp.pslverr && apb_rsp.prdata == DATA_ZERO) else $error("unmapped access");
  a_dma_after_max: assert property ($rose(dma_req)
    |-> $past(osc_config_max, 2) || $past(osc_config_max, 3)) else $error("result not after max");
  a_dma_fall_read: assert property ($fell(dma_req) |-> $past(rdv) || age_r < 3'h6)
    else $error("dma request fell without read");
  a_irq_hold: assert property ($fell(irq) |-> age_r < 3'h6)
    else $error("irq fell without write");
  a_win_pulse: assert property (window_event |=> !window_event)
    else $error("window event longer than a cycle");
  a_win_dma: assert property (window_event |-> dma_req)
    else $error("window event without result");
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the thermal measure unit over APB.
// Assumes oscillator idle (zero difference, result equals offset), no standby or halt.
`timescale 1ns/1ps
module tb;
  import thermal_measure_pkg::*;
  logic        pclk, presetn, sev, ocm, irq, dma, wev;
  apb_req_s    req;
  apb_rsp_s    rsp;
  logic [31:0] rd;
  logic        er;
  int          n_mismatch, num_checks;
  thermal_measure_unit thermal_measure_unit_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .apb_req(req), .apb_rsp(rsp), .temp_dependent_oscillator(1'b0), .start_event_in(sev),
    .standby_sleep(1'b0), .debug_halt(1'b0), .osc_config_max(ocm), .irq(irq),
    .dma_req(dma), .window_event(wev));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task summarize;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task fail(input string m);
    n_mismatch++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task cmp(input logic [31:0] a, input logic [31:0] b);
    num_checks++;
    if (a !== b) fail($sformatf("got %h want %h", a, b));
  endtask
  task apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, {i, 2'h0}, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 40);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 40) begin
      fail("apb timeout");
      summarize;
    end
  endtask
  task en(input logic [31:0] v);
    int n;
    apb(1'b1, IDX_CTRL_A, v);
    n = 0;
    do begin
      apb(1'b0, IDX_SYNC, 0);
      n++;
    end while (rd[1:0] !== 2'h0 && n < 20);
    if (n >= 20) begin
      fail("sync timeout");
      summarize;
    end
  endtask
  task wdma;
    int n;
    n = 0;
    while (dma !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) begin
      fail("result timeout");
      summarize;
    end
  endtask
  task meas(input logic [2:0] m, input logic [23:0] v, input logic [3:0] e);
    en(0);
    apb(1'b1, IDX_CTRL_C, 32'(m));
    apb(1'b1, IDX_OFFSET, 32'(v));
    en(32'h2);
    apb(1'b1, IDX_CTRL_B, 32'h1);
    wdma;
    apb(1'b0, IDX_VALUE, 0);
    cmp(rd, 32'(v));
    apb(1'b0, IDX_IRQ_FLAG, 0);
    cmp(rd, 32'(e));
    cmp(32'(irq), 32'h1);
    apb(1'b1, IDX_IRQ_FLAG, 32'hf);
    apb(1'b0, IDX_IRQ_FLAG, 0);
    cmp(32'(irq), 32'h0);
  endtask
  task t_init;
    apb(1'b0, IDX_CTRL_A, 0);
    cmp(rd, 32'h0);
    apb(1'b0, 10'h300, 0);
    cmp(32'(er), 32'h1);
    apb(1'b1, IDX_GAIN, 32'h4);
    apb(1'b1, IDX_LOWER, 32'h3);
    apb(1'b1, IDX_UPPER, 32'h8);
    apb(1'b1, IDX_EVENT, 32'h4);
    apb(1'b1, IDX_IRQ_SET, 32'hf);
  endtask
  task t_prot;
    apb(1'b1, IDX_CTRL_A, 32'h2);
    apb(1'b0, IDX_CTRL_A, 0);
    cmp(rd, 32'h2);
    en(32'h2);
    apb(1'b1, IDX_GAIN, 32'h9);
    apb(1'b0, IDX_GAIN, 0);
    cmp(rd, 32'h4);
    apb(1'b1, IDX_IRQ_CLR, 32'h2);
    apb(1'b0, IDX_IRQ_SET, 0);
    cmp(rd, 32'hd);
    apb(1'b1, IDX_IRQ_SET, 32'h2);
  endtask
  task t_win;
    logic [2:0]  m [10] = '{0, 1, 2, 3, 4, 4, 5, 6, 3, 0};
    logic [23:0] v [10] = '{5, 5, 5, 5, 5, 10, 10, 1, 9, 24'h01_0000};
    logic [3:0]  e [10] = '{1, 5, 5, 5, 1, 5, 5, 5, 1, 9};
    for (int k = 0; k < 10; k++) meas(m[k], v[k], e[k]);
  endtask
  task t_ovr;
    int n;
    apb(1'b1, IDX_CTRL_B, 32'h1);
    wdma;
    apb(1'b1, IDX_CTRL_B, 32'h1);
    n = 0;
    do begin
      apb(1'b0, IDX_IRQ_FLAG, 0);
      n++;
    end while (rd[1] !== 1'b1 && n < 30);
    cmp(32'(rd[1]), 32'h1);
    apb(1'b0, IDX_VALUE, 0);
    apb(1'b1, IDX_IRQ_FLAG, 32'hf);
  endtask
  task t_free;
    en(0);
    apb(1'b1, IDX_CTRL_C, 32'h10);
    en(32'h2);
    wdma;
    apb(1'b0, IDX_VALUE, 0);
    @(posedge pclk);
    cmp(32'(dma), 32'h0);
    wdma;
    en(0);
    apb(1'b1, IDX_CTRL_C, 0);
  endtask
  task t_event;
    apb(1'b1, IDX_EVENT, 32'h1);
    en(32'h2);
    apb(1'b0, IDX_VALUE, 0);
    @(posedge pclk);
    cmp(32'(dma), 32'h0);
    sev <= 1'b1;
    wdma;
    apb(1'b0, IDX_VALUE, 0);
    cmp(rd, 32'h0001_0000);
    sev <= 1'b0;
  endtask
  task t_soft_reset;
    en(32'h3);
    apb(1'b0, IDX_CTRL_A, 0);
    cmp(rd, 32'h0);
    apb(1'b0, IDX_EVENT, 0);
    cmp(rd, 32'h0);
    apb(1'b0, IDX_GAIN, 0);
    cmp(rd, 32'h4);
  endtask
  initial begin
    req = '0;
    sev = 1'b0;
    presetn = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_init;
    t_prot;
    t_win;
    t_ovr;
    t_free;
    t_event;
    t_soft_reset;
    summarize;
  end
endmodule
bind thermal_measure_unit thermal_measure_monitor thermal_measure_monitor_i (.pclk(pclk),
  .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .osc_config_max(osc_config_max),
  .irq(irq), .dma_req(dma_req), .window_event(window_event));
